/* File: verilog/cbtx_pkg.sv */
// Package with constants and types for the bit-flag and transfer unit
package cbtx_pkg;
    // Bus register byte offsets
    localparam logic [7:0] OFF_GPR_LAST = 8'h7C;
    localparam logic [7:0] OFF_INSTR = 8'h80;
    localparam logic [7:0] OFF_OPERAND = 8'h84;
    localparam logic [7:0] OFF_STATUS = 8'h88;
    localparam logic [7:0] OFF_SP = 8'h8C;
    localparam logic [7:0] OFF_EXEC = 8'h90;
    // Instruction word fields
    localparam int F_OP_LSB = 0;
    localparam int F_REG_LSB = 5;
    localparam int F_BIT_LSB = 10;
    localparam int F_DISP_LSB = 13;
    localparam int F_PTR_LSB = 19;
    // Execution status bit positions
    localparam int X_BUSY = 0;
    localparam int X_ILLEGAL = 1;
    localparam int X_HALT = 2;
    // Status register flag positions
    localparam logic [2:0] FLAG_WRAP = 3'h3;
    localparam logic [2:0] FLAG_POLARITY = 3'h4;
    localparam logic [2:0] FLAG_NIBBLE = 3'h5;
    localparam logic [2:0] FLAG_SPARE = 3'h6;
    // Pointer pair selectors and their low register index
    localparam logic [1:0] PSEL_FIRST = 2'h0;
    localparam logic [1:0] PSEL_SECOND = 2'h1;
    localparam logic [1:0] PSEL_THIRD = 2'h2;
    localparam logic [4:0] PTR_FIRST_LO = 5'h1A;
    localparam logic [4:0] PTR_SECOND_LO = 5'h1C;
    localparam logic [4:0] PTR_THIRD_LO = 5'h1E;
    localparam logic [4:0] FIRST_GENERAL_REG = 5'h00;
    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] SP_RESET = 16'h01FF;

    // Command codes written to the instruction register
    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_FLAG_SET = 5'h01,
        OP_FLAG_CLR = 5'h02,
        OP_COPY_BIT_TO_FLAG = 5'h03,
        OP_COPY_FLAG_TO_BIT = 5'h04,
        OP_IREAD = 5'h05,
        OP_IREAD_INC = 5'h06,
        OP_IREAD_DEC = 5'h07,
        OP_OFFSET_READ = 5'h08,
        OP_IWRITE = 5'h09,
        OP_IWRITE_INC = 5'h0A,
        OP_IWRITE_DEC = 5'h0B,
        OP_OFFSET_WRITE = 5'h0C,
        OP_DIRECT_READ = 5'h0D,
        OP_DIRECT_WRITE = 5'h0E,
        OP_PREAD_FIRST = 5'h0F,
        OP_PREAD = 5'h10,
        OP_PREAD_INC = 5'h11,
        OP_PUSH = 5'h12,
        OP_POP = 5'h13,
        OP_HALT = 5'h14
    } cbtx_op_t;

    typedef enum logic [1:0] {S_IDLE, S_PWAIT, S_FINISH} cbtx_state_t;

    // Data memory request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } cbtx_dreq_t;

    // Program memory request
    typedef struct packed {
        logic [15:0] addr;
        logic re;
    } cbtx_preq_t;
endpackage

/* File: verilog/cbtx_unit.sv */
// Bit-flag and data-transfer execution unit with Wishbone register access
// Notes on behaviour
// - Bit to spare flag; one cycle, no other flag.
// - Spare flag to bit; one cycle, flags kept.
// - Polarity flag set or clear; one cycle, alone.
// - Wrap flag set or clear; one cycle, alone.
// - Nibble-carry set: half carry to 1, alone.
// - Nibble-carry clear: half carry to 0, alone.
// - Read at pointer, then pointer+1; two cycles.
// - Pointer-1, then read; two cycles.
// - Read at second/third pointer+offset; pointer kept.
// - Store at pointer, then pointer+1; two cycles.
// - Pointer-1, then store; two cycles.
// - Store at second/third pointer+offset; pointer kept.
// - Direct read, instruction address; two cycles.
// - Direct write, instruction address; two cycles.
// - Program read via third pair, three cycles; bare form to r0.
// - Push in two cycles, flags kept.
// - Pop in two cycles, flags kept.
// - Debug halt: debug only, no defined cycle count.
//
// Implementation choices: the address map and the Wishbone register port.

`timescale 1ns/1ps
`default_nettype none
module cbtx_unit #(
    parameter logic [15:0] SP_INIT = cbtx_pkg::SP_RESET
) (
    input wire logic clk_i, // Core clock, 100 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    output var cbtx_pkg::cbtx_dreq_t dmem_o, // Data memory request
    input wire logic [7:0] dmem_rdata_i, // Data memory read byte
    output var cbtx_pkg::cbtx_preq_t pmem_o, // Program memory request
    input wire logic [7:0] pmem_rdata_i, // Program memory read byte
    output logic [7:0] status_o, // Status register copy
    output logic busy_o // Instruction in progress
);

    // Merge two written bytes under their selects
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0] sel);
        merge16 = {sel[1] ? new_v[15:8] : old_v[15:8],
                   sel[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    // Low register index of a pointer pair
    function automatic logic [4:0] ptr_lo(input logic [1:0] psel);
        case (psel)
            cbtx_pkg::PSEL_FIRST: ptr_lo = cbtx_pkg::PTR_FIRST_LO;
            cbtx_pkg::PSEL_SECOND: ptr_lo = cbtx_pkg::PTR_SECOND_LO;
            default: ptr_lo = cbtx_pkg::PTR_THIRD_LO;
        endcase
    endfunction

    // Architectural state
    logic [7:0] gpr [32];
    logic [7:0] status_register;
    logic [15:0] sp;
    logic [15:0] operand_k;
    logic illegal;
    logic halt_seen;
    cbtx_pkg::cbtx_state_t state;

    // Context of the running instruction
    logic [4:0] cur_rd;
    logic [4:0] cur_plo;
    logic [15:0] cur_ptr;
    logic cur_ptr_upd;
    logic cur_sp_upd;
    logic [15:0] cur_sp;
    logic cur_dload;
    logic cur_pload;

    // Bus decode; writes stall while an instruction runs
    wire idle = (state == cbtx_pkg::S_IDLE);
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_take = wb_req & (~wb_we_i | idle);
    wire wb_wr = wb_take & wb_we_i;

    wire is_gpr = (wb_adr_i <= cbtx_pkg::OFF_GPR_LAST);
    wire [4:0] gpr_idx = wb_adr_i[6:2];
    wire wr_gpr = wb_wr & is_gpr & wb_sel_i[0];

    wire wr_instr = wb_wr & (wb_adr_i == cbtx_pkg::OFF_INSTR);
    wire wr_operand = wb_wr & (wb_adr_i == cbtx_pkg::OFF_OPERAND);
    wire wr_status = wb_wr & (wb_adr_i == cbtx_pkg::OFF_STATUS)
                     & wb_sel_i[0];
    wire wr_sp = wb_wr & (wb_adr_i == cbtx_pkg::OFF_SP);
    wire wr_exec = wb_wr & (wb_adr_i == cbtx_pkg::OFF_EXEC)
                   & wb_sel_i[0];

    // Instruction fields
    wire [4:0] op_raw = wb_dat_i[cbtx_pkg::F_OP_LSB +: 5];
    wire cbtx_pkg::cbtx_op_t op = cbtx_pkg::cbtx_op_t'(op_raw);

    wire [4:0] rsel = wb_dat_i[cbtx_pkg::F_REG_LSB +: 5];
    wire [2:0] bsel = wb_dat_i[cbtx_pkg::F_BIT_LSB +: 3];
    wire [5:0] disp = wb_dat_i[cbtx_pkg::F_DISP_LSB +: 6];
    wire [1:0] psel = wb_dat_i[cbtx_pkg::F_PTR_LSB +: 2];

    // Operation classes
    wire op_inc = (op == cbtx_pkg::OP_IREAD_INC)
                  | (op == cbtx_pkg::OP_IWRITE_INC);

    wire op_dec = (op == cbtx_pkg::OP_IREAD_DEC)
                  | (op == cbtx_pkg::OP_IWRITE_DEC);

    wire op_ofs = (op == cbtx_pkg::OP_OFFSET_READ)
                  | (op == cbtx_pkg::OP_OFFSET_WRITE);

    wire op_ind = op_inc | op_dec | op_ofs
                  | (op == cbtx_pkg::OP_IREAD)
                  | (op == cbtx_pkg::OP_IWRITE);

    wire op_prog = (op == cbtx_pkg::OP_PREAD_FIRST)
                   | (op == cbtx_pkg::OP_PREAD)
                   | (op == cbtx_pkg::OP_PREAD_INC);

    wire op_dread = (op == cbtx_pkg::OP_IREAD)
                    | (op == cbtx_pkg::OP_IREAD_INC)
                    | (op == cbtx_pkg::OP_IREAD_DEC)
                    | (op == cbtx_pkg::OP_OFFSET_READ)
                    | (op == cbtx_pkg::OP_DIRECT_READ)
                    | (op == cbtx_pkg::OP_POP);

    wire op_dwrite = (op == cbtx_pkg::OP_IWRITE)
                     | (op == cbtx_pkg::OP_IWRITE_INC)
                     | (op == cbtx_pkg::OP_IWRITE_DEC)
                     | (op == cbtx_pkg::OP_OFFSET_WRITE)
                     | (op == cbtx_pkg::OP_DIRECT_WRITE)
                     | (op == cbtx_pkg::OP_PUSH);

    wire op_data = op_dread | op_dwrite;

    // Legal codes; offset forms only use the second or third pair
    wire bad_code = (op_raw > cbtx_pkg::OP_HALT);
    wire bad_ptr = op_ind & (psel == 2'h3);
    wire bad_ofs = op_ofs & (psel == cbtx_pkg::PSEL_FIRST);
    wire instr_bad = bad_code | bad_ptr | bad_ofs;

    wire go = wr_instr & ~instr_bad;

    // Pointer selection; program reads always use the third pair
    wire [4:0] plo = op_prog ? cbtx_pkg::PTR_THIRD_LO
                             : ptr_lo(psel);
    wire [4:0] phi = {plo[4:1], 1'b1};
    wire [15:0] ptr = {gpr[phi], gpr[plo]};

    wire [15:0] ptr_up = ptr + 16'h0001;
    wire [15:0] ptr_down = ptr - 16'h0001;
    wire [15:0] ptr_ofs = ptr + {10'h000, disp};

    wire [15:0] sp_up = sp + 16'h0001;
    wire [15:0] sp_down = sp - 16'h0001;

    // Effective data address
    logic [15:0] eff_addr;
    always_comb begin
        if (op_dec) begin
            eff_addr = ptr_down;
        end else if (op_ofs) begin
            eff_addr = ptr_ofs;
        end else if ((op == cbtx_pkg::OP_DIRECT_READ)
                     | (op == cbtx_pkg::OP_DIRECT_WRITE)) begin
            eff_addr = operand_k;
        end else if (op == cbtx_pkg::OP_PUSH) begin
            eff_addr = sp;
        end else if (op == cbtx_pkg::OP_POP) begin
            eff_addr = sp_up;
        end else begin
            eff_addr = ptr;
        end
    end

    // Destination register; the bare program read targets register 0
    wire [4:0] dest = (op == cbtx_pkg::OP_PREAD_FIRST)
                      ? cbtx_pkg::FIRST_GENERAL_REG : rsel;

    wire ptr_upd = op_inc | op_dec | (op == cbtx_pkg::OP_PREAD_INC);
    wire [15:0] ptr_next = op_dec ? ptr_down : ptr_up;

    wire stack_op = (op == cbtx_pkg::OP_PUSH) | (op == cbtx_pkg::OP_POP);
    wire [15:0] sp_next = (op == cbtx_pkg::OP_PUSH) ? sp_down : sp_up;

    // Flags that software clears by writing one; a new event wins
    wire clr_illegal = wr_exec & wb_dat_i[cbtx_pkg::X_ILLEGAL];
    wire clr_halt = wr_exec & wb_dat_i[cbtx_pkg::X_HALT];

    wire set_halt = go & (op == cbtx_pkg::OP_HALT);

    // Bus read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (is_gpr) begin
            rd_mux = {24'h00_0000, gpr[gpr_idx]};
        end else if (wb_adr_i == cbtx_pkg::OFF_OPERAND) begin
            rd_mux = {16'h0000, operand_k};
        end else if (wb_adr_i == cbtx_pkg::OFF_STATUS) begin
            rd_mux = {24'h00_0000, status_register};
        end else if (wb_adr_i == cbtx_pkg::OFF_SP) begin
            rd_mux = {16'h0000, sp};
        end else if (wb_adr_i == cbtx_pkg::OFF_EXEC) begin
            rd_mux = {29'h0000_0000, halt_seen, illegal, ~idle};
        end
    end

    // Wishbone answer one cycle after the request is taken, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_take;
            if (wb_take) begin
                wb_dat_o <= rd_mux;
            end
        end
    end

    // Operand and sticky execution flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            operand_k <= 16'h0000;
            illegal <= 1'b0;
            halt_seen <= 1'b0;
        end else begin
            if (wr_operand) begin
                operand_k <= merge16(operand_k, wb_dat_i[15:0],
                                     wb_sel_i[1:0]);
            end
            illegal <= (wr_instr & instr_bad) | (illegal & ~clr_illegal);
            halt_seen <= set_halt | (halt_seen & ~clr_halt);
        end
    end

    // Sequencer and memory requests
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= cbtx_pkg::S_IDLE;
            dmem_o <= '0;
            pmem_o <= '0;
            busy_o <= 1'b0;

            cur_rd <= 5'h00;
            cur_plo <= 5'h00;
            cur_ptr <= 16'h0000;
            cur_ptr_upd <= 1'b0;
            cur_sp_upd <= 1'b0;
            cur_sp <= 16'h0000;
            cur_dload <= 1'b0;
            cur_pload <= 1'b0;
        end else begin
            unique case (state)
                cbtx_pkg::S_IDLE: begin
                    if (go & (op_data | op_prog)) begin
                        cur_rd <= dest;
                        cur_plo <= plo;
                        cur_ptr <= ptr_next;
                        cur_ptr_upd <= ptr_upd;
                        cur_sp_upd <= stack_op;
                        cur_sp <= sp_next;
                        cur_dload <= op_dread;
                        cur_pload <= op_prog;
                        busy_o <= 1'b1;
                    end

                    if (go & op_data) begin
                        // Two cycles: issue now, finish next edge
                        dmem_o.addr <= eff_addr;
                        dmem_o.wdata <= gpr[rsel];
                        dmem_o.we <= op_dwrite;
                        dmem_o.re <= op_dread;
                        state <= cbtx_pkg::S_FINISH;
                    end else if (go & op_prog) begin
                        // Three cycles: synchronous program memory
                        pmem_o.addr <= ptr;
                        pmem_o.re <= 1'b1;
                        state <= cbtx_pkg::S_PWAIT;
                    end
                end

                cbtx_pkg::S_PWAIT: begin
                    pmem_o.re <= 1'b0;
                    state <= cbtx_pkg::S_FINISH;
                end

                cbtx_pkg::S_FINISH: begin
                    dmem_o <= '0;
                    busy_o <= 1'b0;
                    state <= cbtx_pkg::S_IDLE;
                end
            endcase
        end
    end

    // Register file, status register and stack pointer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_register <= cbtx_pkg::STATUS_RESET;
            sp <= SP_INIT;
            status_o <= cbtx_pkg::STATUS_RESET;
        end else begin
            if (wr_gpr) begin
                gpr[gpr_idx] <= wb_dat_i[7:0];
            end

            if (wr_sp) begin
                sp <= merge16(sp, wb_dat_i[15:0], wb_sel_i[1:0]);
            end

            if (wr_status) begin
                status_register <= wb_dat_i[7:0];
                status_o <= wb_dat_i[7:0];
            end

            if (go & (op == cbtx_pkg::OP_FLAG_SET)) begin
                // Only the chosen flag bit moves
                status_register[bsel] <= 1'b1;
                status_o[bsel] <= 1'b1;
            end

            if (go & (op == cbtx_pkg::OP_FLAG_CLR)) begin
                status_register[bsel] <= 1'b0;
                status_o[bsel] <= 1'b0;
            end

            if (go & (op == cbtx_pkg::OP_COPY_BIT_TO_FLAG)) begin
                status_register[cbtx_pkg::FLAG_SPARE] <=
                    gpr[rsel][bsel];
                status_o[cbtx_pkg::FLAG_SPARE] <= gpr[rsel][bsel];
            end

            if (go & (op == cbtx_pkg::OP_COPY_FLAG_TO_BIT)) begin
                // Status register left alone
                gpr[rsel][bsel] <=
                    status_register[cbtx_pkg::FLAG_SPARE];
            end

            if (state == cbtx_pkg::S_FINISH) begin
                // Data lands on the last edge; no flag is touched
                if (cur_dload) begin
                    gpr[cur_rd] <= dmem_rdata_i;
                end

                if (cur_pload) begin
                    gpr[cur_rd] <= pmem_rdata_i;
                end

                // Pointer written last, so it wins over an overlapping load
                if (cur_ptr_upd) begin
                    gpr[cur_plo] <= cur_ptr[7:0];
                    gpr[{cur_plo[4:1], 1'b1}] <= cur_ptr[15:8];
                end

                if (cur_sp_upd) begin
                    sp <= cur_sp;
                end
            end
        end
    end

endmodule // cbtx_unit
`default_nettype wire

/* File: sim/cbtx_mem_model.sv */
// Data and program memory model for the transfer unit
`timescale 1ns/1ps
`default_nettype none
module cbtx_mem_model (
    input wire logic clk_i, // Core clock
    input wire cbtx_pkg::cbtx_dreq_t dreq_i, // Data memory request
    input wire cbtx_pkg::cbtx_preq_t preq_i, // Program memory request
    output logic [7:0] drd_o, // Data read byte
    output logic [7:0] prd_o // Program read byte
);
    logic [7:0] mem [256];
    logic [7:0] junk = 8'h5A;
    // Bytes start as an address pattern
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h3C;
        end
    end
    // Async read; a released line toggles so stale data shows
    assign drd_o = dreq_i.re ? mem[dreq_i.addr[7:0]] : junk;
    // Writes land at the edge; the ROM answers in the cycle after re
    always @(posedge clk_i) begin
        junk <= ~junk;
        if (dreq_i.we)
            mem[dreq_i.addr[7:0]] <= dreq_i.wdata;
        prd_o <= preq_i.re ? preq_i.addr[7:0] + 8'h11 : ~prd_o;
    end
endmodule // cbtx_mem_model
`default_nettype wire

/* File: sim/cbtx_unit_sva.sv */
// Port checker for the transfer unit
`timescale 1ns/1ps
`default_nettype none
module cbtx_unit_sva (
    input wire logic clk_i, // Core clock
    input wire logic rst_i, // Sync reset
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_we_i, // Bus write
    input wire logic [7:0] wb_adr_i, // Bus address
    input wire logic [31:0] wb_dat_i, // Bus write data
    input wire logic wb_ack_o, // Bus acknowledge
    input wire cbtx_pkg::cbtx_dreq_t dmem_o, // Data request
    input wire cbtx_pkg::cbtx_preq_t pmem_o, // Program request
    input wire logic [7:0] status_o, // Status copy
    input wire logic busy_o // Busy
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Accepted instruction write and its decode
    wire take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !busy_o
        && wb_adr_i == 8'h80;
    wire [4:0] op = wb_dat_i[4:0];
    wire [1:0] ps = wb_dat_i[20:19];
    wire [7:0] fm = 8'h01 << wb_dat_i[12:10];
    wire ptr = op >= 5'h05 && op <= 5'h0C;
    wire off = op == 5'h08 || op == 5'h0C;
    // Refused pointer choices must start nothing
    wire bad = (ptr && ps == 2'h3) || (off && ps == 2'h0);
    wire dop = take && !bad && (ptr || op == 5'h0D || op == 5'h0E
        || op == 5'h12 || op == 5'h13);
    wire prd = take && op >= 5'h0F && op <= 5'h11;

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    read_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i
        && !wb_ack_o |=> wb_ack_o) else $error("read not answered");
    flag_set_a: assert property (
        take && op == 5'h01 |=> status_o == ($past(status_o) | $past(fm)))
        else $error("flag set wrong");
    flag_clr_a: assert property (
        take && op == 5'h02 |=> status_o == ($past(status_o) & ~$past(fm)))
        else $error("flag clear wrong");
    spare_only_a: assert property (
        take && op == 5'h03
        |=> (status_o & 8'hBF) == ($past(status_o) & 8'hBF))
        else $error("bit copy touched other flags");
    bit_load_a: assert property (
        take && op == 5'h04 |=> $stable(status_o))
        else $error("flag to bit changed flags");
    data_two_a: assert property (
        dop |=> busy_o && (dmem_o.we || dmem_o.re)
        ##1 !busy_o && !dmem_o.we && !dmem_o.re)
        else $error("transfer not two cycles");
    data_flags_a: assert property (
        dop |=> ##1 status_o == $past(status_o, 2))
        else $error("transfer changed flags");
    prog_three_a: assert property (
        prd |=> busy_o && pmem_o.re ##1 busy_o && !pmem_o.re ##1 !busy_o)
        else $error("program read not three cycles");
    push_wr_a: assert property (
        take && op == 5'h12 |=> dmem_o.we && !dmem_o.re)
        else $error("push without store");
    pop_rd_a: assert property (
        take && op == 5'h13 |=> dmem_o.re && !dmem_o.we)
        else $error("pop without load");
    halt_quiet_a: assert property (
        take && op == 5'h14 |=> !busy_o && $stable(status_o))
        else $error("halt had effects");
    refused_a: assert property ((take && (bad || op > 5'h14))
        |=> !busy_o && !dmem_o.we && !dmem_o.re)
        else $error("refused code ran");

    cover property (dop);
    cover property (prd);
    cover property (take && op == 5'h01);
endmodule // cbtx_unit_sva
bind cbtx_unit cbtx_unit_sva chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .dmem_o(dmem_o), .pmem_o(pmem_o), .status_o(status_o),
    .busy_o(busy_o));
`default_nettype wire

/* File: sim/tb_cpu_bitflag_and_transfer_exec.sv */
// Self-checking bench for the transfer unit
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_bitflag_and_transfer_exec;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic bus_on = 1'b0;
    logic bus_we = 1'b0;
    logic rd_pend = 1'b0;
    logic [7:0] bus_adr = 8'h00;
    logic [31:0] bus_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic busy_o;
    logic [7:0] status_o, drd, prd, st, v;
    logic [7:0] rnd = 8'h15;
    logic [2:0] fl [3] = '{cbtx_pkg::FLAG_WRAP, cbtx_pkg::FLAG_POLARITY,
        cbtx_pkg::FLAG_NIBBLE};
    cbtx_pkg::cbtx_dreq_t dmem_o, e;
    cbtx_pkg::cbtx_preq_t pmem_o;
    cbtx_pkg::cbtx_dreq_t dq[$];
    logic [31:0] rq[$];
    int mismatches = 0;
    int checks = 0;

    always #5 clk_i = ~clk_i;

    // Selects are tied full: every register is taken whole
    cbtx_unit dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(bus_on),
        .wb_stb_i(bus_on), .wb_we_i(bus_we), .wb_adr_i(bus_adr),
        .wb_sel_i(4'hF), .wb_dat_i(bus_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .dmem_o(dmem_o), .dmem_rdata_i(drd),
        .pmem_o(pmem_o), .pmem_rdata_i(prd), .status_o(status_o),
        .busy_o(busy_o));
    cbtx_mem_model mem (.clk_i(clk_i), .dreq_i(dmem_o), .preq_i(pmem_o),
        .drd_o(drd), .prd_o(prd));

    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] dm(input logic [7:0] a);
        return a ^ 8'h3C;
    endfunction
    task automatic fail(input string m);
        mismatches++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task automatic conclude;
        $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Classic single cycle, held until ack is seen at an edge
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        {bus_on, bus_we, bus_adr, bus_dat} <= {1'b1, w, a, d};
        rd_pend <= !w;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20)
            fail("no ack");
        {bus_on, rd_pend} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        rq.push_back(x);
        wb(1'b0, a, 32'h0);
    endtask
    task automatic sr(input logic [4:0] i, input logic [7:0] d);
        wb(1'b1, {1'b0, i, 2'b00}, {24'h0, d});
    endtask
    task automatic rr(input logic [4:0] i, input logic [7:0] x);
        rd({1'b0, i, 2'b00}, {24'h0, x});
    endtask
    task automatic sp(input logic [4:0] i, input logic [15:0] d);
        sr(i, d[7:0]);
        sr(i + 5'h01, d[15:8]);
    endtask
    task automatic pr(input logic [4:0] i, input logic [15:0] x);
        rr(i, x[7:0]);
        rr(i + 5'h01, x[15:8]);
    endtask
    task automatic dx(input logic [15:0] a, input logic [7:0] d = 8'h00,
        input logic w = 1'b0);
        dq.push_back({a, d, w, !w});
    endtask
    task automatic ex(input logic [4:0] op, r, input logic [2:0] b = 3'h0,
        input logic [5:0] q = 6'h00, input logic [1:0] p = 2'h0);
        wb(1'b1, 8'h80, {11'h0, p, q, b, r, op});
        while (busy_o === 1'b1)
            @(posedge clk_i);
    endtask

    // Check each answer against its oldest note
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && rd_pend === 1'b1) begin
            checks++;
            if (rq.size() == 0 || wb_dat_o !== rq[0])
                fail("read data");
            if (rq.size() != 0)
                void'(rq.pop_front());
        end
        if (!rst_i && (dmem_o.we !== 1'b0 || dmem_o.re !== 1'b0)) begin
            checks++;
            if (dq.size() == 0) begin
                fail("unexpected memory request");
            end else begin
                e = dq.pop_front();
                if ({dmem_o.addr, dmem_o.we, dmem_o.re} !== {e.addr, e.we, e.re}
                    || (e.we && dmem_o.wdata !== e.wdata))
                    fail("memory request");
            end
        end
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        fail("watchdog");
        conclude();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h88, 32'h0);
        rd(8'h8C, 32'h01FF);
        rd(8'hA0, 32'h0);
        $display("Test reset values done");
        // Wrap, polarity and nibble flags each set and cleared over random neighbours
        for (int i = 0; i < 6; i++) begin
            rnd = nx(rnd);
            wb(1'b1, 8'h88, {24'h0, rnd});
            ex(i[0] ? 5'h02 : 5'h01, 5'h00, fl[i / 2]);
            v = 8'h01 << fl[i / 2];
            rd(8'h88, {24'h0, i[0] ? rnd & ~v : rnd | v});
        end
        // Bit copies, with the target bit forced to change
        rnd = nx(rnd);
        v = nx(rnd);
        v[2] = ~rnd[5];
        st = nx(v);
        st[6] = ~rnd[5];
        sr(5'h03, rnd);
        sr(5'h04, v);
        wb(1'b1, 8'h88, {24'h0, st});
        ex(5'h03, 5'h03, 3'h5);
        st[6] = rnd[5];
        rd(8'h88, {24'h0, st});
        ex(5'h04, 5'h04, 3'h2);
        v[2] = st[6];
        rr(5'h04, v);
        rd(8'h88, {24'h0, st});
        $display("Test flags done");
        // Pointer traffic; 00FF steps across the byte boundary
        sp(5'h1A, 16'h00FF);
        sp(5'h1C, 16'h0020);
        sp(5'h1E, 16'h0030);
        rnd = nx(rnd);
        sr(5'h05, rnd);
        dx(16'h00FF);
        ex(5'h06, 5'h06);
        rr(5'h06, dm(8'hFF));
        pr(5'h1A, 16'h0100);
        dx(16'h00FF);
        ex(5'h07, 5'h07);
        rr(5'h07, dm(8'hFF));
        pr(5'h1A, 16'h00FF);
        dx(16'h005F);
        ex(5'h08, 5'h08, 3'h0, 6'h3F, 2'h1);
        rr(5'h08, dm(8'h5F));
        pr(5'h1C, 16'h0020);
        dx(16'h0035, dm(8'hFF), 1'b1);
        ex(5'h0C, 5'h06, 3'h0, 6'h05, 2'h2);
        pr(5'h1E, 16'h0030);
        dx(16'h0020, rnd, 1'b1);
        ex(5'h0A, 5'h05, 3'h0, 6'h00, 2'h1);
        pr(5'h1C, 16'h0021);
        dx(16'h002F, rnd, 1'b1);
        ex(5'h0B, 5'h05, 3'h0, 6'h00, 2'h2);
        pr(5'h1E, 16'h002F);
        wb(1'b1, 8'h84, 32'h0077);
        dx(16'h0077);
        ex(5'h0D, 5'h09);
        rr(5'h09, dm(8'h77));
        wb(1'b1, 8'h84, 32'h0099);
        dx(16'h0099, rnd, 1'b1);
        ex(5'h0E, 5'h05);
        // Two pushes then a pop must return the later byte
        dx(16'h01FF, rnd, 1'b1);
        ex(5'h12, 5'h05);
        dx(16'h01FE, dm(8'hFF), 1'b1);
        ex(5'h12, 5'h06);
        dx(16'h01FE);
        ex(5'h13, 5'h0A);
        rr(5'h0A, dm(8'hFF));
        rd(8'h8C, 32'h01FE);
        rd(8'h88, {24'h0, st});
        $display("Test transfers done");
        // Program reads at third pair 002F; the ROM gives address + 11
        ex(5'h0F, 5'h03);
        rr(5'h00, 8'h40);
        ex(5'h10, 5'h0B);
        ex(5'h11, 5'h0C);
        rr(5'h0B, 8'h40);
        rr(5'h0C, 8'h40);
        pr(5'h1E, 16'h0030);
        // Halt, a refused offset form and an unknown code
        ex(5'h14, 5'h00);
        rd(8'h90, 32'h4);
        ex(5'h08, 5'h08, 3'h0, 6'h01);
        ex(5'h15, 5'h00);
        rd(8'h90, 32'h6);
        rd(8'h88, {24'h0, st});
        $display("Test halt and refusals done");
        if (dq.size() != 0 || rq.size() != 0)
            fail("notes left over");
        conclude();
    end
endmodule // tb_cpu_bitflag_and_transfer_exec
`default_nettype wire
